// ### shared/reg_frame_defs.svh
// register offsets, field positions, reset values and the lock key
// assumes an 8-bit register port with a 7-bit address
`ifndef REG_FRAME_DEFS_SVH
`define REG_FRAME_DEFS_SVH

`define A_REV        7'h00
`define A_ID_LSB     7'h01
`define A_ID_MSB     7'h02
`define A_SCRATCH    7'h03
`define A_KEY_MSB    7'h04
`define A_KEY_LSB    7'h05
`define A_PULSE      7'h06
`define A_DEV_CTRL   7'h08
`define A_DEV_ALARM  7'h10
`define A_DEV_EN     7'h11
`define A_DEV_SUM    7'h12
`define A_CH_BASE    7'h20
`define A_CH_STRIDE  7'h10
`define O_CH_CTRL    4'h0
`define O_CH_STAT    4'h1
`define O_CH_ALARM   4'h2
`define O_CH_EN      4'h3
`define UNLOCK_KEY   16'ha001
`define KEY_RST      16'h0000
`define SCRATCH_RST  8'h00
`define DEV_CTRL_RST 8'h00
`define CH_CTRL_RST  8'h00
`define EN_RST       8'h00
`define P_SOFT_RST   0
`define P_FIFO_ALIGN 1
`define B_WERR       0
`define B_SUM_DEV    4

`endif

// ### shared/reg_frame_pkg.sv
// types shared by the register framework
package reg_frame_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] addr_t;
endpackage : reg_frame_pkg

// ### hdl/reg_frame.sv
// locked register framework: generic, device and four channel blocks
// assumes single-cycle strobes, synchronous inputs, one master
`timescale 1ns/10ps
`include "reg_frame_defs.svh"
module reg_frame #(
    parameter int NCH = 4,
    parameter logic [7:0] REV_CODE = 8'h11, // arbitrary value
    parameter logic [15:0] ID_CODE = 16'h5a5a // arbitrary value
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // register port
    input wire reg_frame_pkg::addr_t i_addr,
    input wire reg_frame_pkg::byte_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output reg_frame_pkg::byte_t o_rdata,
    // device events and status
    input wire logic [7:0] i_dev_event,
    input wire logic [8*NCH-1:0] i_ch_status,
    input wire logic [8*NCH-1:0] i_ch_event,
    // controls, pulses and the summary interrupt
    output reg_frame_pkg::byte_t o_dev_ctrl,
    output logic [8*NCH-1:0] o_ch_ctrl,
    output logic o_soft_rst,
    output logic o_fifo_align,
    output logic o_irq_sum
);
    import reg_frame_pkg::*;

    typedef struct packed {
        byte_t rdata;
        byte_t scratch;
        logic [15:0] key;
        byte_t dev_ctrl;
        byte_t dev_alarm;
        byte_t dev_en;
        logic [8*NCH-1:0] ch_ctrl;
        logic [8*NCH-1:0] ch_alarm;
        logic [8*NCH-1:0] ch_en;
        logic soft_rst;
        logic fifo_align;
        logic irq;
    } state_t;

    state_t s_q, s_d;
    logic [1:0] rsync_q;
    logic rst_n;
    assign rst_n = rsync_q[1];

    logic unlocked;
    logic [NCH-1:0] ch_sum;
    logic dev_sum;
    byte_t sum_reg;

    always_comb
    begin
        unlocked = s_q.key == `UNLOCK_KEY;
        for (int c = 0; c < NCH; c++)
        begin
            ch_sum[c] = |(s_q.ch_alarm[8*c+:8] & s_q.ch_en[8*c+:8]);
        end
        dev_sum = |(s_q.dev_alarm & s_q.dev_en);
        sum_reg = 8'h00;
        sum_reg[NCH-1:0] = ch_sum;
        sum_reg[`B_SUM_DEV] = dev_sum;
    end

    always_comb
    begin
        logic prot;
        logic hit;
        logic [6:0] rel;
        logic [1:0] ci;
        logic [3:0] off;
        byte_t rd;
        s_d = s_q;
        prot = 1'b0;
        hit = 1'b0;
        rel = 7'h00;
        ci = 2'h0;
        off = 4'h0;
        rd = 8'h00;
        s_d.soft_rst = 1'b0;
        s_d.fifo_align = 1'b0;
        // latch events, set wins over clear
        s_d.dev_alarm = s_q.dev_alarm | i_dev_event;
        s_d.ch_alarm = s_q.ch_alarm | i_ch_event;
        if (i_addr >= `A_CH_BASE
            && i_addr < 7'(`A_CH_BASE + NCH * `A_CH_STRIDE))
        begin
            rel = 7'(i_addr - `A_CH_BASE);
            ci = rel[5:4];
            off = rel[3:0];
            hit = 1'b1;
        end
        // write decode
        if (i_wr)
        begin
            if (i_addr == `A_SCRATCH)
            begin
                s_d.scratch = i_wdata;
            end
            else if (i_addr == `A_KEY_MSB)
            begin
                // both key halves stay open, else a locked part never unlocks
                s_d.key[15:8] = i_wdata;
            end
            else if (i_addr == `A_KEY_LSB)
            begin
                s_d.key[7:0] = i_wdata;
            end
            else if (i_addr == `A_PULSE)
            begin
                prot = 1'b1;
                if (unlocked)
                begin
                    s_d.soft_rst = i_wdata[`P_SOFT_RST];
                    s_d.fifo_align = i_wdata[`P_FIFO_ALIGN];
                end
            end
            else if (i_addr == `A_DEV_CTRL)
            begin
                prot = 1'b1;
                if (unlocked)
                    s_d.dev_ctrl = i_wdata;
            end
            else if (i_addr == `A_DEV_ALARM)
            begin
                prot = 1'b1;
                if (unlocked)
                    s_d.dev_alarm = (s_q.dev_alarm & ~i_wdata)
                        | i_dev_event;
            end
            else if (i_addr == `A_DEV_EN)
            begin
                prot = 1'b1;
                if (unlocked)
                    s_d.dev_en = i_wdata;
            end
            else if (hit && off == `O_CH_CTRL)
            begin
                prot = 1'b1;
                if (unlocked)
                    s_d.ch_ctrl[8*ci+:8] = i_wdata;
            end
            else if (hit && off == `O_CH_ALARM)
            begin
                prot = 1'b1;
                if (unlocked)
                    s_d.ch_alarm[8*ci+:8] = (s_q.ch_alarm[8*ci+:8]
                        & ~i_wdata) | i_ch_event[8*ci+:8];
            end
            else if (hit && off == `O_CH_EN)
            begin
                prot = 1'b1;
                if (unlocked)
                    s_d.ch_en[8*ci+:8] = i_wdata;
            end
            else
            begin
                prot = 1'b1; // status and unmapped drop write data, but a locked write still sets the error flag
            end
            if (prot && !unlocked)
                s_d.dev_alarm[`B_WERR] = 1'b1;
        end
        // read decode, data stands the cycle after the strobe
        if (i_addr == `A_REV)
            rd = REV_CODE;
        else if (i_addr == `A_ID_LSB)
            rd = ID_CODE[7:0];
        else if (i_addr == `A_ID_MSB)
            rd = ID_CODE[15:8];
        else if (i_addr == `A_SCRATCH)
            rd = s_q.scratch;
        else if (i_addr == `A_KEY_MSB)
            rd = s_q.key[15:8];
        else if (i_addr == `A_KEY_LSB)
            rd = s_q.key[7:0];
        else if (i_addr == `A_PULSE)
            rd = 8'h00;
        else if (i_addr == `A_DEV_CTRL)
            rd = s_q.dev_ctrl;
        else if (i_addr == `A_DEV_ALARM)
            rd = s_q.dev_alarm;
        else if (i_addr == `A_DEV_EN)
            rd = s_q.dev_en;
        else if (i_addr == `A_DEV_SUM)
            rd = sum_reg;
        else if (hit && off == `O_CH_CTRL)
            rd = s_q.ch_ctrl[8*ci+:8];
        else if (hit && off == `O_CH_STAT)
            rd = i_ch_status[8*ci+:8];
        else if (hit && off == `O_CH_ALARM)
            rd = s_q.ch_alarm[8*ci+:8];
        else if (hit && off == `O_CH_EN)
            rd = s_q.ch_en[8*ci+:8];
        s_d.rdata = i_rd ? rd : 8'h00;
        s_d.irq = dev_sum | (|ch_sum);
        // soft reset restores control defaults, alarms and key
        if (s_q.soft_rst)
        begin
            s_d.dev_ctrl = `DEV_CTRL_RST;
            s_d.ch_ctrl = {NCH{`CH_CTRL_RST}};
            s_d.dev_en = `EN_RST;
            s_d.ch_en = {NCH{`EN_RST}};
            s_d.key = `KEY_RST;
            s_d.dev_alarm = i_dev_event;
            s_d.ch_alarm = i_ch_event;
            s_d.scratch = `SCRATCH_RST;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            rsync_q <= 2'b00;
        else
            rsync_q <= {rsync_q[0], 1'b1};
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.rdata <= 8'h00;
            s_q.scratch <= `SCRATCH_RST;
            s_q.key <= `KEY_RST;
            s_q.dev_ctrl <= `DEV_CTRL_RST;
            s_q.dev_alarm <= 8'h00;
            s_q.dev_en <= `EN_RST;
            s_q.ch_ctrl <= {NCH{`CH_CTRL_RST}};
            s_q.ch_alarm <= '0;
            s_q.ch_en <= {NCH{`EN_RST}};
            s_q.soft_rst <= 1'b0;
            s_q.fifo_align <= 1'b0;
            s_q.irq <= 1'b0;
        end
        else
        begin
            s_q.rdata <= s_d.rdata;
            s_q.scratch <= s_d.scratch;
            s_q.key <= s_d.key;
            s_q.dev_ctrl <= s_d.dev_ctrl;
            s_q.dev_alarm <= s_d.dev_alarm;
            s_q.dev_en <= s_d.dev_en;
            s_q.ch_ctrl <= s_d.ch_ctrl;
            s_q.ch_alarm <= s_d.ch_alarm;
            s_q.ch_en <= s_d.ch_en;
            s_q.soft_rst <= s_d.soft_rst;
            s_q.fifo_align <= s_d.fifo_align;
            s_q.irq <= s_d.irq;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_dev_ctrl = s_q.dev_ctrl;
    assign o_ch_ctrl = s_q.ch_ctrl;
    assign o_soft_rst = s_q.soft_rst;
    assign o_fifo_align = s_q.fifo_align;
    assign o_irq_sum = s_q.irq;

    a_pulse_single: assert property (@(posedge i_clk) disable iff (!rst_n)
        s_q.soft_rst && !(i_wr && i_addr == `A_PULSE)
        |=> !s_q.soft_rst)
        else $error("soft reset pulse longer than one cycle");
    a_pulse_read: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_rd && i_addr == `A_PULSE |=> o_rdata == 8'h00)
        else $error("pulse register read nonzero");
    a_locked_ctrl: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_wr && !unlocked && !s_q.soft_rst |=> $stable(o_dev_ctrl)
        && $stable(o_ch_ctrl))
        else $error("control changed while locked");
    a_denied_flag: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_wr && !unlocked && i_addr == `A_DEV_CTRL && !s_q.soft_rst
        |=> s_q.dev_alarm[`B_WERR])
        else $error("denied write did not set error flag");
    a_scratch_open: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_wr && i_addr == `A_SCRATCH && !s_q.soft_rst
        |=> s_q.scratch == $past(i_wdata))
        else $error("scratch pad write lost");
    a_alarm_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_dev_event[1] && !s_q.soft_rst |=> s_q.dev_alarm[1])
        else $error("device alarm not latched");
    a_irq_or: assert property (@(posedge i_clk) disable iff (!rst_n)
        (dev_sum || ch_sum != '0) |=> o_irq_sum)
        else $error("summary not raised");
    a_mask_block: assert property (@(posedge i_clk) disable iff (!rst_n)
        (s_q.dev_en == 8'h00 && s_q.ch_en == '0) |=> !o_irq_sum)
        else $error("masked event propagated");
    a_ctrl_default: assert property (@(posedge i_clk) disable iff (!rst_n)
        s_q.soft_rst |=> o_dev_ctrl == `DEV_CTRL_RST
        && s_q.key == `KEY_RST)
        else $error("soft reset did not restore defaults");

    a_pulse_fifo: assert property (@(posedge i_clk) disable iff (!rst_n)
        s_q.fifo_align && !(i_wr && i_addr == `A_PULSE)
        |=> !s_q.fifo_align)
        else $error("fifo align pulse longer than one cycle");

    a_pulse_fire: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_wr && unlocked && i_addr == `A_PULSE && i_wdata[`P_SOFT_RST]
        |=> o_soft_rst)
        else $error("soft reset pulse missing");

    a_ctrl_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
        !i_wr && !s_q.soft_rst |=> $stable(o_dev_ctrl)
        && $stable(o_ch_ctrl))
        else $error("control changed without a write");

    a_gap_zero: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_rd && i_addr == 7'h07 |=> o_rdata == 8'h00)
        else $error("unmapped address read nonzero");

    a_rev_fixed: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_rd && i_addr == `A_REV |=> o_rdata == REV_CODE)
        else $error("revision read wrong");

    a_id_fixed: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_rd && i_addr == `A_ID_MSB |=> o_rdata == ID_CODE[15:8])
        else $error("identity read wrong");

    a_key_low: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_wr && i_addr == `A_KEY_LSB && !s_q.soft_rst
        |=> s_q.key[7:0] == $past(i_wdata))
        else $error("key low byte write lost");

    a_key_high: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_wr && i_addr == `A_KEY_MSB && !s_q.soft_rst
        |=> s_q.key[15:8] == $past(i_wdata))
        else $error("key high byte write lost");

    a_alarm_clear: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_wr && unlocked && i_addr == `A_DEV_ALARM && i_wdata[1]
        && !i_dev_event[1] && !s_q.soft_rst
        |=> !s_q.dev_alarm[1])
        else $error("alarm not cleared by written one");

    a_alarm_keep: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_wr && i_addr == `A_DEV_ALARM && !i_wdata[1] && s_q.dev_alarm[1]
        && !s_q.soft_rst |=> s_q.dev_alarm[1])
        else $error("alarm cleared by written zero");

    a_sum_reg: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_rd && i_addr == `A_DEV_SUM |=> o_rdata == $past(sum_reg))
        else $error("summary read wrong");

    a_sum_unused: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_rd && i_addr == `A_DEV_SUM |=> o_rdata[7:5] == 3'h0)
        else $error("unused summary bits nonzero");

    a_irq_low: assert property (@(posedge i_clk) disable iff (!rst_n)
        !dev_sum && ch_sum == '0 |=> !o_irq_sum)
        else $error("summary raised with no source");

    a_soft_en: assert property (@(posedge i_clk) disable iff (!rst_n)
        s_q.soft_rst |=> s_q.dev_en == `EN_RST
        && s_q.ch_ctrl == {NCH{`CH_CTRL_RST}})
        else $error("soft reset left enables or controls");

    a_werr_pulse: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_wr && !unlocked && i_addr == `A_PULSE && !s_q.soft_rst
        |=> s_q.dev_alarm[`B_WERR])
        else $error("denied pulse write not flagged");

    a_scratch_quiet: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_wr && !unlocked && i_addr == `A_SCRATCH && !s_q.soft_rst
        && !s_q.dev_alarm[`B_WERR] && !i_dev_event[`B_WERR]
        |=> !s_q.dev_alarm[`B_WERR])
        else $error("scratch write flagged as denied");

    a_en_locked: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_wr && !unlocked && !s_q.soft_rst
        |=> $stable(s_q.ch_en) && $stable(s_q.dev_en))
        else $error("enable changed while locked");
endmodule : reg_frame

// ### tb/locked_register_framework_test.sv
// self-checking bench for the locked register framework
// assumes both key halves stay writable while locked
`timescale 1ns/10ps
`include "reg_frame_defs.svh"
module locked_register_framework_test;
import reg_frame_pkg::*;
localparam logic [7:0] REV = 8'h3c; // arbitrary value
localparam logic [15:0] IDC = 16'hc3a5; // arbitrary value
logic i_clk;
logic i_nrst;
logic i_wr;
logic i_rd;
addr_t i_addr;
byte_t i_wdata;
byte_t o_rdata;
byte_t o_dev_ctrl;
byte_t rd_val;
logic [7:0] i_dev_event;
logic [31:0] i_ch_status;
logic [31:0] i_ch_event;
logic [31:0] o_ch_ctrl;
logic o_soft_rst;
logic o_fifo_align;
logic o_irq_sum;
int pulse_cnt = 0;
int num_errors;
int checks_done;

reg_frame #(.NCH(4), .REV_CODE(REV), .ID_CODE(IDC)) dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_dev_event(i_dev_event), .i_ch_status(i_ch_status),
    .i_ch_event(i_ch_event), .o_dev_ctrl(o_dev_ctrl),
    .o_ch_ctrl(o_ch_ctrl), .o_soft_rst(o_soft_rst),
    .o_fifo_align(o_fifo_align), .o_irq_sum(o_irq_sum)
);

initial
begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
end

// pulses last one cycle, so a cycle-counting monitor counts each cycle in which either of them is high
always @(posedge i_clk)
begin
    if (o_soft_rst === 1'b1 || o_fifo_align === 1'b1)
        pulse_cnt <= pulse_cnt + 1;
end

task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask : tally_and_finish

task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
        num_errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask : chk

task wr(input addr_t a, input byte_t d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
endtask : wr

task rchk(input addr_t a, input byte_t e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd_val = o_rdata;
    chk(rd_val, e);
endtask : rchk

function automatic addr_t ch_addr(input int ch, input logic [3:0] off);
    return addr_t'(`A_CH_BASE + `A_CH_STRIDE * ch + off);
endfunction : ch_addr

task do_reset;
    i_nrst <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    // two-flop release plus one spare edge before the first request
    repeat (3) @(posedge i_clk);
endtask : do_reset

task test_reset_values;
    rchk(`A_REV, REV);
    rchk(`A_ID_LSB, IDC[7:0]);
    rchk(`A_ID_MSB, IDC[15:8]);
    rchk(`A_KEY_MSB, 8'h00);
    rchk(`A_KEY_LSB, 8'h00);
    rchk(`A_PULSE, 8'h00);
    rchk(`A_DEV_CTRL, `DEV_CTRL_RST);
    rchk(`A_DEV_SUM, 8'h00);
    rchk(7'h07, 8'h00);
    rchk(7'h7f, 8'h00);
    chk(o_ch_ctrl, 32'h0);
    $display("test reset values done");
endtask : test_reset_values

task test_scratch;
    wr(`A_SCRATCH, 8'h55);
    rchk(`A_SCRATCH, 8'h55);
    wr(`A_SCRATCH, 8'haa);
    rchk(`A_SCRATCH, 8'haa);
    rchk(`A_DEV_ALARM, 8'h00);
    $display("test scratch done");
endtask : test_scratch

task test_lock_denied;
    int p0;
    p0 = pulse_cnt;
    wr(`A_DEV_CTRL, 8'hff);
    chk(o_dev_ctrl, 8'h00);
    rchk(`A_DEV_CTRL, 8'h00);
    rchk(`A_DEV_ALARM, 8'h01);
    wr(ch_addr(2, `O_CH_CTRL), 8'h5a);
    chk(o_ch_ctrl, 32'h0);
    wr(`A_PULSE, 8'h03);
    repeat (3) @(posedge i_clk);
    chk(32'(pulse_cnt - p0), 32'h0);
    wr(`A_KEY_LSB, 8'h01);
    rchk(`A_KEY_LSB, 8'h01);
    rchk(`A_KEY_MSB, 8'h00);
    // a locked clear is itself a denied write, so the flag must stay
    wr(`A_DEV_ALARM, 8'h01);
    rchk(`A_DEV_ALARM, 8'h01);
    rchk(`A_DEV_SUM, 8'h00);
    chk(o_irq_sum, 1'b0);
    $display("test lock denied done");
endtask : test_lock_denied

task test_channel_status;
    @(posedge i_clk);
    i_ch_status <= 32'h44332211;
    repeat (3) @(posedge i_clk);
    for (int ch = 0; ch < 4; ch++)
        rchk(ch_addr(ch, `O_CH_STAT), 8'(8'h11 * (ch + 1)));
    wr(ch_addr(1, `O_CH_STAT), 8'h00);
    rchk(ch_addr(1, `O_CH_STAT), 8'h22);
    $display("test channel status done");
endtask : test_channel_status

task test_alarm_latch;
    @(posedge i_clk);
    i_ch_event[8 * 2 + 3] <= 1'b1;
    @(posedge i_clk);
    i_ch_event <= 32'h0;
    repeat (3) @(posedge i_clk);
    rchk(ch_addr(2, `O_CH_ALARM), 8'h08);
    rchk(ch_addr(1, `O_CH_ALARM), 8'h00);
    rchk(ch_addr(2, `O_CH_EN), `EN_RST);
    rchk(`A_DEV_SUM, 8'h00);
    chk(o_irq_sum, 1'b0);
    $display("test alarm latch done");
endtask : test_alarm_latch

task test_unlocked;
    int p0;
    wr(`A_KEY_MSB, 8'ha0);
    wr(`A_KEY_LSB, 8'h01);
    rchk(`A_KEY_MSB, 8'ha0);
    wr(`A_DEV_CTRL, 8'h3c);
    chk(o_dev_ctrl, 8'h3c);
    rchk(`A_DEV_CTRL, 8'h3c);
    wr(ch_addr(3, `O_CH_CTRL), 8'h5a);
    chk(o_ch_ctrl, 32'h5a000000);
    wr(ch_addr(2, `O_CH_EN), 8'h08);
    rchk(`A_DEV_SUM, 8'h04);
    chk(o_irq_sum, 1'b1);
    wr(ch_addr(2, `O_CH_ALARM), 8'h00);
    rchk(ch_addr(2, `O_CH_ALARM), 8'h08);
    wr(ch_addr(2, `O_CH_ALARM), 8'h08);
    rchk(ch_addr(2, `O_CH_ALARM), 8'h00);
    rchk(`A_DEV_SUM, 8'h00);
    chk(o_irq_sum, 1'b0);
    wr(`A_DEV_ALARM, 8'h01);
    rchk(`A_DEV_ALARM, 8'h00);
    p0 = pulse_cnt;
    wr(`A_PULSE, 8'h02);
    @(posedge i_clk);
    #1;
    chk(32'(pulse_cnt - p0), 32'h1);
    rchk(`A_PULSE, 8'h00);
    chk(o_dev_ctrl, 8'h3c);
    wr(`A_PULSE, 8'h01);
    @(posedge i_clk);
    #1;
    chk(o_dev_ctrl, `DEV_CTRL_RST);
    chk(o_ch_ctrl, 32'h0);
    rchk(`A_KEY_MSB, 8'h00);
    wr(`A_DEV_CTRL, 8'h11);
    chk(o_dev_ctrl, 8'h00);
    $display("test unlocked done");
endtask : test_unlocked

task test_second_reset;
    i_ch_status <= 32'h0;
    do_reset();
    rchk(`A_SCRATCH, `SCRATCH_RST);
    rchk(`A_KEY_LSB, 8'h00);
    rchk(`A_DEV_ALARM, 8'h00);
    rchk(ch_addr(2, `O_CH_ALARM), 8'h00);
    $display("test second reset done");
endtask : test_second_reset

initial
begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 7'h00;
    i_wdata = 8'h00;
    i_dev_event = 8'h00;
    i_ch_status = 32'h0;
    i_ch_event = 32'h0;
    num_errors = 0;
    checks_done = 0;
    do_reset();
    test_reset_values();
    test_scratch();
    test_lock_denied();
    test_channel_status();
    test_alarm_latch();
    test_unlocked();
    test_second_reset();
    tally_and_finish();
end

// the whole run needs well under a thousand cycles
initial
begin
    #20000;
    num_errors++;
    tally_and_finish();
end
endmodule : locked_register_framework_test
